// ===== shared/ubt_pkg.sv
package ubt_pkg;
	localparam int CLK_PERIOD_NS  = 8;
	localparam int TICK_PERIOD_NS = 1_000_000;
	localparam int TICK_CYCLES    = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TICK_CNT_W     = 17;

	localparam int NUM_STAGES    = 4;
	localparam int STAGE_IDX_W   = 2;
	localparam int EVT_TYPES     = 6;
	localparam int EVT_TYPE_W    = 3;
	localparam int NUM_EVT       = NUM_STAGES * EVT_TYPES;
	localparam int EVT_IDX_W     = 5;
	localparam int EVT_START_ON  = 0;
	localparam int EVT_TRIP_ON   = 2;
	localparam int EVT_BLOCK_ON  = 4;
	localparam int SIG_PER_STAGE = 3;
	localparam int IRQ_REC_BIT   = NUM_STAGES * SIG_PER_STAGE;
	localparam int IRQ_W         = IRQ_REC_BIT + 1;

	localparam int MAG_W      = 16;
	localparam int STAMP_W    = 32;
	localparam int GROUP_W    = 3;
	localparam int DATA_W     = 32;
	localparam int ADDR_W     = 8;
	localparam int BYTE_W     = 8;
	localparam int BYTES      = DATA_W / BYTE_W;
	localparam int WORD_BYTES = 4;
	localparam int SQ_W       = 32;
	localparam int ACC_W      = 48;
	localparam int CMP_W      = 48;

	localparam int NUM_RECORDS    = 12;
	localparam int REC_PTR_W      = 4;
	localparam int REC_WORDS      = 7;
	localparam int REC_W          = REC_WORDS * DATA_W;
	localparam int REC_WORD_IDX_W = 3;

	localparam int RELEASE_DEFAULT_MS = 60;
	localparam int AVG_WINDOW_MS      = 20;
	localparam int PREFAULT_MS        = 200;
	localparam int HIST_DEPTH         = PREFAULT_MS / AVG_WINDOW_MS;
	localparam int AVG_CNT_W          = 5;
	localparam int AVG_SUM_W          = 21;
	localparam int AVG_PROD_W         = 40;
	localparam int AVG_SCALE          = 3277;
	localparam int AVG_SHIFT          = 16;
	localparam int PCT_FULL           = 100;
	localparam int DROPOUT_PCT        = 97;
	localparam int RATIO_SCALE        = 10000;

	typedef enum logic [1:0] {UBT_INSTANT, UBT_DEFINITE, UBT_INVERSE} ubt_mode_t;
	typedef enum logic [1:0] {UBT_BUS_IDLE, UBT_BUS_CAPT, UBT_BUS_DONE} ubt_bus_t;
	localparam logic [1:0] MODE_MAX = 2'h2;

	localparam int CFG_MODE_LSB   = 0;
	localparam int CFG_MODE_W     = 2;
	localparam int CFG_SQUARED_DIFFERENCE_CURVE_BIT = 2;
	localparam int CFG_RELOPT_BIT = 3;
	localparam int CFG_RATIO_BIT  = 4;
	localparam int CFG_EVTEN_LSB  = 8;

	localparam logic [7:0] REG_IRQ_STATUS = 8'h00;
	localparam logic [7:0] REG_IRQ_MASK   = 8'h04;
	localparam logic [7:0] REG_STAMP      = 8'h08;
	localparam logic [7:0] REG_REC_SEL    = 8'h0C;
	localparam logic [7:0] REG_REC_BASE   = 8'h10;
	localparam logic [7:0] REG_STAGE_BASE = 8'h40;
	localparam logic [7:0] STAGE_STRIDE   = 8'h20;
	localparam logic [7:0] STG_CFG        = 8'h00;
	localparam logic [7:0] STG_PICKUP     = 8'h04;
	localparam logic [7:0] STG_DELAY      = 8'h08;
	localparam logic [7:0] STG_KMULT      = 8'h0C;
	localparam logic [7:0] STG_RELDLY     = 8'h10;
	localparam logic [7:0] STG_STATUS     = 8'h14;

	localparam logic [31:0] CFG_RESET    = 32'h0000_3F01;
	localparam logic [15:0] PICKUP_RESET = 16'h0014;
	localparam logic [15:0] DELAY_RESET  = 16'h0064;
	localparam logic [15:0] KMULT_RESET  = 16'h0001;
	localparam logic [15:0] RELDLY_RESET = 16'(RELEASE_DEFAULT_MS);
endpackage

// ===== src/ubt_record_mem.sv
`timescale 1ns/1ps
module ubt_record_mem
	import ubt_pkg::*;
#(
	parameter int W     = REC_W,
	parameter int DEPTH = NUM_RECORDS,
	parameter int AW    = REC_PTR_W
) (
	input  wire logic          ref_clk,
	input  wire logic          wrEn,
	input  wire logic [AW-1:0] wrAddr,
	input  wire logic [W-1:0]  wrData,
	input  wire logic [AW-1:0] rdAddr,
	output logic      [W-1:0]  rdData
);
	logic [W-1:0] mem [DEPTH];

	always_ff @(posedge ref_clk) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
		rdData <= mem[rdAddr];
	end
endmodule // ubt_record_mem

// ===== src/ubt_unbalance_timer.sv
`timescale 1ns/1ps
module ubt_unbalance_timer
	import ubt_pkg::*;
#(
	parameter int TICK_CYCLES_P = TICK_CYCLES
) (
	input  wire logic                   ref_clk,
	input  wire logic                   rst,
	input  wire logic [ADDR_W-1:0]      avs_address,
	input  wire logic                   avs_read,
	input  wire logic                   avs_write,
	input  wire logic [DATA_W-1:0]      avs_writedata,
	input  wire logic [BYTES-1:0]       avs_byteenable,
	output logic      [DATA_W-1:0]      avs_readdata,
	output logic                        avs_waitrequest,
	output logic                        irq,
	input  wire logic [MAG_W-1:0]       measNegSeqMag,
	input  wire logic [MAG_W-1:0]       measPosSeqMag,
	input  wire logic [MAG_W-1:0]       measZeroSeqMag,
	input  wire logic [MAG_W-1:0]       measNegSeqAng,
	input  wire logic [MAG_W-1:0]       measPosSeqAng,
	input  wire logic [MAG_W-1:0]       measZeroSeqAng,
	input  wire logic [GROUP_W-1:0]     settingGroup,
	input  wire logic [NUM_STAGES-1:0]  blockIn,
	output logic      [NUM_STAGES-1:0]  startOut,
	output logic      [NUM_STAGES-1:0]  tripOut,
	output logic      [NUM_STAGES-1:0]  blockedOut,
	output logic                        evtValid,
	input  wire logic                   evtReady,
	output logic      [STAGE_IDX_W-1:0] evtStage,
	output logic      [EVT_TYPE_W-1:0]  evtType,
	output logic      [STAMP_W-1:0]     evtStamp
);
	logic [TICK_CNT_W-1:0]     tickCnt_q;
	logic                      tick_q;
	logic [STAMP_W-1:0]        stamp_q;
	logic [AVG_CNT_W-1:0]      winCnt_q;
	logic [AVG_SUM_W-1:0]      winSum_q;
	logic [AVG_SUM_W-1:0]      winSum_d;
	logic [AVG_PROD_W-1:0]     avgProd;
	logic [MAG_W-1:0]          avg_q;
	logic [MAG_W-1:0]          hist_q [HIST_DEPTH];
	ubt_bus_t                  phase_q;
	logic                      busReq;
	logic                      rdAcc;
	logic                      wrAcc;
	logic [DATA_W-1:0]         beMask;
	logic [DATA_W-1:0]         rdMux;
	logic [ADDR_W-1:0]         stgRel;
	logic [ADDR_W-1:0]         stgIdx;
	logic [ADDR_W-1:0]         stgOff;
	logic                      inStage;
	logic [ADDR_W-1:0]         recRel;
	logic [DATA_W-1:0]         cfg_q    [NUM_STAGES];
	logic [MAG_W-1:0]          pickSet_q [NUM_STAGES];
	logic [MAG_W-1:0]          delay_q  [NUM_STAGES];
	logic [MAG_W-1:0]          kmul_q   [NUM_STAGES];
	logic [MAG_W-1:0]          relDly_q [NUM_STAGES];
	logic [MAG_W-1:0]          remain   [NUM_STAGES];
	logic [STAMP_W-1:0]        stgStamp_q [NUM_STAGES];
	logic [NUM_STAGES-1:0]     pickup_q;
	logic [NUM_EVT-1:0]        pend_q;
	logic [NUM_EVT-1:0]        setAll;
	logic [NUM_EVT-1:0]        evtEnAll;
	logic [EVT_IDX_W-1:0]      selIdx;
	logic [STAGE_IDX_W-1:0]    selStage;
	logic [EVT_TYPE_W-1:0]     selType;
	logic                      load;
	logic                      recWr;
	logic [REC_PTR_W-1:0]      wrPtr_q;
	logic [REC_PTR_W-1:0]      recCount_q;
	logic [REC_PTR_W-1:0]      recSel_q;
	logic [REC_PTR_W:0]        rdPtrRaw;
	logic [REC_PTR_W-1:0]      rdPtr;
	logic [REC_W-1:0]          recData;
	logic [REC_W-1:0]          recRd;
	logic [IRQ_W-1:0]          irqStatus_q;
	logic [IRQ_W-1:0]          irqMask_q;
	logic [IRQ_W-1:0]          irqSet;
	logic [IRQ_W-1:0]          irqClr;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old);
		merge = (old & ~beMask) | (avs_writedata & beMask);
	endfunction

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			tickCnt_q <= '0;
			tick_q    <= 1'b0;
		end else if (tickCnt_q == TICK_CNT_W'(TICK_CYCLES_P - 1)) begin
			tickCnt_q <= '0;
			tick_q    <= 1'b1;
		end else begin
			tickCnt_q <= tickCnt_q + 1'b1;
			tick_q    <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			stamp_q <= '0;
		end else if (tick_q) begin
			stamp_q <= stamp_q + 1'b1;
		end
	end

	assign winSum_d = winSum_q + AVG_SUM_W'(measNegSeqMag);
	assign avgProd  = AVG_PROD_W'(winSum_d) * AVG_PROD_W'(AVG_SCALE);

	// Block averages, not a sliding window: the pre-trigger value may be up to one window stale.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			winCnt_q <= '0;
			winSum_q <= '0;
			avg_q    <= '0;
			for (int i = 0; i < HIST_DEPTH; i++) begin
				hist_q[i] <= '0;
			end
		end else if (tick_q) begin
			if (winCnt_q == AVG_CNT_W'(AVG_WINDOW_MS - 1)) begin
				winCnt_q <= '0;
				winSum_q <= '0;
				avg_q    <= avgProd[AVG_SHIFT +: MAG_W];
				hist_q[0] <= avg_q;
				for (int i = 1; i < HIST_DEPTH; i++) begin
					hist_q[i] <= hist_q[i - 1];
				end
			end else begin
				winCnt_q <= winCnt_q + 1'b1;
				winSum_q <= winSum_d;
			end
		end
	end

	assign busReq          = avs_read | avs_write;
	assign avs_waitrequest = busReq && (phase_q != UBT_BUS_DONE);
	assign rdAcc           = avs_read && (phase_q == UBT_BUS_DONE);
	assign wrAcc           = avs_write && (phase_q == UBT_BUS_DONE);
	assign stgRel          = avs_address - REG_STAGE_BASE;
	assign stgIdx          = stgRel / STAGE_STRIDE;
	assign stgOff          = stgRel % STAGE_STRIDE;
	assign inStage         = (avs_address >= REG_STAGE_BASE) && (stgIdx < ADDR_W'(NUM_STAGES));
	assign recRel          = (avs_address - REG_REC_BASE) / ADDR_W'(WORD_BYTES);

	for (genvar b = 0; b < BYTES; b++) begin : g_be
		assign beMask[b * BYTE_W +: BYTE_W] = {BYTE_W{avs_byteenable[b]}};
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			phase_q <= UBT_BUS_IDLE;
		end else begin
			unique case (phase_q)
				UBT_BUS_IDLE: if (busReq) begin
					phase_q <= UBT_BUS_CAPT;
				end
				UBT_BUS_CAPT: phase_q <= UBT_BUS_DONE;
				UBT_BUS_DONE: phase_q <= UBT_BUS_IDLE;
			endcase
		end
	end

	always_comb begin
		rdMux = '0;
		if (inStage) begin
			unique case (stgOff)
				STG_CFG:    rdMux = cfg_q[stgIdx[STAGE_IDX_W-1:0]];
				STG_PICKUP: rdMux = DATA_W'(pickSet_q[stgIdx[STAGE_IDX_W-1:0]]);
				STG_DELAY:  rdMux = DATA_W'(delay_q[stgIdx[STAGE_IDX_W-1:0]]);
				STG_KMULT:  rdMux = DATA_W'(kmul_q[stgIdx[STAGE_IDX_W-1:0]]);
				STG_RELDLY: rdMux = DATA_W'(relDly_q[stgIdx[STAGE_IDX_W-1:0]]);
				STG_STATUS: rdMux = DATA_W'({pickup_q[stgIdx[STAGE_IDX_W-1:0]],
					blockedOut[stgIdx[STAGE_IDX_W-1:0]], tripOut[stgIdx[STAGE_IDX_W-1:0]],
					startOut[stgIdx[STAGE_IDX_W-1:0]]});
				default:    rdMux = '0;
			endcase
		end else begin
			unique case (avs_address)
				REG_IRQ_STATUS: rdMux = DATA_W'(irqStatus_q);
				REG_IRQ_MASK:   rdMux = DATA_W'(irqMask_q);
				REG_STAMP:      rdMux = stamp_q;
				REG_REC_SEL:    rdMux = DATA_W'({recCount_q, recSel_q});
				default: begin
					if (avs_address >= REG_REC_BASE && recRel < ADDR_W'(REC_WORDS)
							&& recSel_q < recCount_q) begin
						rdMux = recRd[recRel[REC_WORD_IDX_W-1:0] * DATA_W +: DATA_W];
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			avs_readdata <= '0;
		end else if (phase_q == UBT_BUS_CAPT) begin
			avs_readdata <= rdMux;
		end
	end

	for (genvar s = 0; s < NUM_STAGES; s++) begin : g_stage
		logic [CFG_MODE_W-1:0] modeRaw;
		ubt_mode_t             mode;
		logic                  squared_difference_curve;
		logic                  relOpt;
		logic                  ratio;
		logic                  stWr;
		logic [CMP_W-1:0]      lhs;
		logic [CMP_W-1:0]      rhs;
		logic                  dropNow;
		logic [SQ_W-1:0]       im2;
		logic [SQ_W-1:0]       is2;
		logic [ACC_W-1:0]      inc;
		logic [ACC_W-1:0]      thr;
		logic [ACC_W-1:0]      acc_q;
		logic [MAG_W-1:0]      relCnt_q;
		logic                  startD;
		logic                  blockedD;
		logic                  reached;
		logic [EVT_TYPES-1:0]  evtSet;

		assign modeRaw = cfg_q[s][CFG_MODE_LSB +: CFG_MODE_W];
		assign mode    = (modeRaw > MODE_MAX) ? UBT_DEFINITE : ubt_mode_t'(modeRaw);
		assign squared_difference_curve  = cfg_q[s][CFG_SQUARED_DIFFERENCE_CURVE_BIT];
		assign relOpt  = cfg_q[s][CFG_RELOPT_BIT];
		assign ratio   = cfg_q[s][CFG_RATIO_BIT];
		assign stWr    = wrAcc && inStage && (stgIdx == ADDR_W'(s));
		assign evtEnAll[s * EVT_TYPES +: EVT_TYPES] = cfg_q[s][CFG_EVTEN_LSB +: EVT_TYPES];

		always_ff @(posedge ref_clk or posedge rst) begin
			if (rst) begin
				cfg_q[s]     <= CFG_RESET;
				pickSet_q[s] <= PICKUP_RESET;
				delay_q[s]   <= DELAY_RESET;
				kmul_q[s]    <= KMULT_RESET;
				relDly_q[s]  <= RELDLY_RESET;
			end else if (stWr) begin
				unique case (stgOff)
					STG_CFG:    cfg_q[s]     <= merge(cfg_q[s]);
					STG_PICKUP: pickSet_q[s] <= MAG_W'(merge(DATA_W'(pickSet_q[s])));
					STG_DELAY:  delay_q[s]   <= MAG_W'(merge(DATA_W'(delay_q[s])));
					STG_KMULT:  kmul_q[s]    <= MAG_W'(merge(DATA_W'(kmul_q[s])));
					STG_RELDLY: relDly_q[s]  <= MAG_W'(merge(DATA_W'(relDly_q[s])));
					default: ;
				endcase
			end
		end

		// Ratio mode cross-multiplies instead of dividing, which saves a divider per stage.
		assign lhs     = ratio ? CMP_W'(measNegSeqMag) * CMP_W'(RATIO_SCALE) : CMP_W'(measNegSeqMag);
		assign rhs     = ratio ? CMP_W'(pickSet_q[s]) * CMP_W'(measPosSeqMag) : CMP_W'(pickSet_q[s]);
		assign dropNow = (lhs * CMP_W'(PCT_FULL)) < (rhs * CMP_W'(DROPOUT_PCT));

		always_ff @(posedge ref_clk or posedge rst) begin
			if (rst) begin
				pickup_q[s] <= 1'b0;
			end else begin
				pickup_q[s] <= pickup_q[s] ? !dropNow : (lhs >= rhs);
			end
		end

		assign im2      = SQ_W'(measNegSeqMag) * SQ_W'(measNegSeqMag);
		assign is2      = SQ_W'(pickSet_q[s]) * SQ_W'(pickSet_q[s]);
		assign inc      = (mode == UBT_DEFINITE) ? ACC_W'(1) : ((im2 > is2) ? ACC_W'(im2 - is2) : '0);
		assign thr      = (mode == UBT_DEFINITE) ? ACC_W'(delay_q[s]) :
			squared_difference_curve ? ACC_W'(kmul_q[s]) :
			ACC_W'(kmul_q[s]) * ACC_W'(is2);
		assign reached  = (mode == UBT_INSTANT) || (acc_q >= thr);
		assign startD   = pickup_q[s] && !blockIn[s];
		assign blockedD = pickup_q[s] && blockIn[s];

		always_ff @(posedge ref_clk or posedge rst) begin
			if (rst) begin
				startOut[s]   <= 1'b0;
				tripOut[s]    <= 1'b0;
				blockedOut[s] <= 1'b0;
			end else begin
				startOut[s]   <= startD;
				blockedOut[s] <= blockedD;
				tripOut[s]    <= startD && reached;
			end
		end

		always_ff @(posedge ref_clk or posedge rst) begin
			if (rst) begin
				acc_q    <= '0;
				relCnt_q <= '0;
			end else if (tripOut[s] && !startD) begin
				acc_q    <= '0;
				relCnt_q <= '0;
			end else if (tick_q) begin
				if (startOut[s]) begin
					acc_q    <= acc_q + inc;
					relCnt_q <= '0;
				end else if (acc_q != '0) begin
					if (relOpt) begin
						acc_q <= acc_q + inc;
					end
					if (relCnt_q + 1'b1 >= relDly_q[s]) begin
						acc_q    <= '0;
						relCnt_q <= '0;
					end else begin
						relCnt_q <= relCnt_q + 1'b1;
					end
				end
			end
		end

		assign remain[s] = (mode == UBT_DEFINITE && acc_q < ACC_W'(delay_q[s])) ?
			delay_q[s] - MAG_W'(acc_q) : '0;

		assign evtSet = {~blockedD & blockedOut[s], blockedD & ~blockedOut[s],
			~(startD && reached) & tripOut[s], (startD && reached) & ~tripOut[s],
			~startD & startOut[s], startD & ~startOut[s]};
		assign setAll[s * EVT_TYPES +: EVT_TYPES] = evtSet;
		assign irqSet[s * SIG_PER_STAGE +: SIG_PER_STAGE] =
			{evtSet[EVT_BLOCK_ON], evtSet[EVT_TRIP_ON], evtSet[EVT_START_ON]};

		// A later event joining a stage that still has pending ones reuses the older stamp.
		always_ff @(posedge ref_clk or posedge rst) begin
			if (rst) begin
				stgStamp_q[s] <= '0;
			end else if ((|evtSet) && !(|pend_q[s * EVT_TYPES +: EVT_TYPES])) begin
				stgStamp_q[s] <= stamp_q;
			end
		end

		a_instant_trip: assert property ((mode == UBT_INSTANT) && $rose(startOut[s])
			|-> tripOut[s]) else $error("instant trip missing");
		a_trip_start: assert property (tripOut[s] |-> startOut[s])
			else $error("trip without start");
		a_block_excl: assert property (!(startOut[s] && blockedOut[s]))
			else $error("start and blocked together");
		a_dropout_ratio: assert property ($fell(pickup_q[s]) |-> $past(dropNow))
			else $error("pickup dropped above dropout level");
		a_release_hold: assert property (!startOut[s] && !relOpt && !tripOut[s]
			|=> (acc_q == $past(acc_q)) || (acc_q == '0)) else $error("release not frozen");
		a_dt_trip: assert property ((mode == UBT_DEFINITE) && startD
			&& (acc_q >= ACC_W'(delay_q[s])) |=> tripOut[s]) else $error("definite trip late");
	end

	always_comb begin
		selIdx = '0;
		for (int i = NUM_EVT - 1; i >= 0; i--) begin
			if (pend_q[i]) begin
				selIdx = EVT_IDX_W'(i);
			end
		end
	end

	assign selStage = STAGE_IDX_W'(selIdx / EVT_IDX_W'(EVT_TYPES));
	assign selType  = EVT_TYPE_W'(selIdx % EVT_IDX_W'(EVT_TYPES));
	assign load     = (|pend_q) && (!evtValid || evtReady);
	assign recWr    = load && !selType[0];

	// New events win over the pop of the one being issued.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pend_q <= '0;
		end else begin
			pend_q <= (pend_q & ~(load ? (NUM_EVT'(1) << selIdx) : '0)) | setAll;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			evtValid <= 1'b0;
			evtStage <= '0;
			evtType  <= '0;
			evtStamp <= '0;
		end else if (load) begin
			evtValid <= evtEnAll[selIdx];
			evtStage <= selStage;
			evtType  <= selType;
			evtStamp <= stgStamp_q[selStage];
		end else if (evtReady) begin
			evtValid <= 1'b0;
		end
	end

	assign recData = {DATA_W'({measZeroSeqAng}) << MAG_W, {measPosSeqAng, measNegSeqAng},
		{measNegSeqMag, measZeroSeqMag}, {hist_q[HIST_DEPTH - 1], measPosSeqMag},
		{avg_q, measNegSeqMag}, {remain[selStage], BYTE_W'(settingGroup),
		BYTE_W'({selStage, selType})}, stgStamp_q[selStage]};

	assign rdPtrRaw = (REC_PTR_W + 1)'(wrPtr_q) + (REC_PTR_W + 1)'(NUM_RECORDS - 1)
		- (REC_PTR_W + 1)'(recSel_q);
	assign rdPtr = (rdPtrRaw >= (REC_PTR_W + 1)'(NUM_RECORDS)) ?
		REC_PTR_W'(rdPtrRaw - (REC_PTR_W + 1)'(NUM_RECORDS)) : REC_PTR_W'(rdPtrRaw);

	ubt_record_mem u_records (
		.ref_clk (ref_clk),
		.wrEn    (recWr),
		.wrAddr  (wrPtr_q),
		.wrData  (recData),
		.rdAddr  (rdPtr),
		.rdData  (recRd)
	);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wrPtr_q    <= '0;
			recCount_q <= '0;
		end else if (recWr) begin
			wrPtr_q    <= (wrPtr_q == REC_PTR_W'(NUM_RECORDS - 1)) ? '0 : wrPtr_q + 1'b1;
			recCount_q <= (recCount_q == REC_PTR_W'(NUM_RECORDS)) ? recCount_q : recCount_q + 1'b1;
		end
	end

	assign irqSet[IRQ_REC_BIT] = recWr;
	assign irqClr = (rdAcc && avs_address == REG_IRQ_STATUS) ? avs_readdata[IRQ_W-1:0] : '0;
	assign irq    = |(irqStatus_q & irqMask_q);

	// Only bits the reader actually saw are cleared, so a set during the access survives.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			irqStatus_q <= '0;
			irqMask_q   <= '0;
			recSel_q    <= '0;
		end else begin
			irqStatus_q <= (irqStatus_q & ~irqClr) | irqSet;
			if (wrAcc && avs_address == REG_IRQ_MASK) begin
				irqMask_q <= IRQ_W'(merge(DATA_W'(irqMask_q)));
			end
			if (wrAcc && avs_address == REG_REC_SEL
					&& avs_writedata[REC_PTR_W-1:0] < REC_PTR_W'(NUM_RECORDS)) begin
				recSel_q <= avs_writedata[REC_PTR_W-1:0];
			end
		end
	end

	a_evt_hold: assert property (evtValid && !evtReady |=> evtValid && $stable(evtStage)
		&& $stable(evtType) && $stable(evtStamp)) else $error("event dropped before accept");
	a_record_on: assert property (recWr |-> (selType == EVT_TYPE_W'(EVT_START_ON)
		|| selType == EVT_TYPE_W'(EVT_TRIP_ON) || selType == EVT_TYPE_W'(EVT_BLOCK_ON)))
		else $error("record from off event");
	a_rec_wrap: assert property (recWr && wrPtr_q == REC_PTR_W'(NUM_RECORDS - 1)
		|=> wrPtr_q == '0) else $error("record pointer did not wrap");
endmodule // ubt_unbalance_timer

// ===== tb/ubt_evt_sink.sv
`timescale 1ns/1ps
// Event buffer model: accepts events with random stalls, as a busy buffer would.
module ubt_evt_sink (
	input  wire logic ref_clk,
	input  wire logic rst,
	input  wire logic evtValid,
	output logic      evtReady
);
	integer seed = 25;
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			evtReady <= 1'b0;
		end else begin
			evtReady <= (evtValid && !evtReady) || ($random(seed) % 3 != 0);
		end
	end
endmodule // ubt_evt_sink

// ===== tb/tb_ubt_unbalance_timer.sv
`timescale 1ns/1ps
module tb_ubt_unbalance_timer;
	import ubt_pkg::*;
	localparam int TK = 20;
	logic ref_clk = 0, rst = 1, avs_read = 0, avs_write = 0, irq, avs_waitrequest, evtValid, evtReady;
	logic [7:0]  avs_address = 0;
	logic [31:0] avs_writedata = 0, avs_readdata, evtStamp, q, s1Stamp;
	logic [15:0] neg = 0, ang = 0;
	logic [2:0]  grp = 0, evtType;
	logic [3:0]  blockIn = 0, startOut, tripOut, blockedOut;
	logic [1:0]  evtStage;
	logic [4:0]  expq[$];
	integer seed = 25, fails = 0, totalChecks = 0, n;
	always #4 ref_clk = ~ref_clk;
	ubt_unbalance_timer #(.TICK_CYCLES_P(TK)) dut_u (.ref_clk(ref_clk), .rst(rst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .irq(irq), .measNegSeqMag(neg),
		.measPosSeqMag(16'h0200), .measZeroSeqMag(ang), .measNegSeqAng(ang),
		.measPosSeqAng(ang), .measZeroSeqAng(ang), .settingGroup(grp), .blockIn(blockIn),
		.startOut(startOut), .tripOut(tripOut), .blockedOut(blockedOut), .evtValid(evtValid),
		.evtReady(evtReady), .evtStage(evtStage), .evtType(evtType), .evtStamp(evtStamp));
	ubt_evt_sink sink_u (.ref_clk(ref_clk), .rst(rst), .evtValid(evtValid), .evtReady(evtReady));
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		totalChecks++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic giveVerdict();
		$display("checks %0d mismatches %0d", totalChecks, fails);
		if (fails == 0 && totalChecks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
		int k;
		k = 0;
		@(posedge ref_clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		do begin
			@(posedge ref_clk);
			k++;
		end while (avs_waitrequest !== 1'b0 && k < 50);
		if (k >= 50) chk("waitrequest", avs_waitrequest, 1'b0);
		r = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	function automatic logic [7:0] sa(input int s, input logic [7:0] off);
		return REG_STAGE_BASE + STAGE_STRIDE * 8'(s) + off;
	endfunction
	// Monitor: every accepted event is matched against the oldest expectation.
	always @(posedge ref_clk) begin
		if (evtValid === 1'b1 && evtReady === 1'b1) begin
			if (expq.size() == 0) chk("unexpected event", {evtStage, evtType}, 5'h1F);
			else chk("event id", {evtStage, evtType}, expq.pop_front());
			if ({evtStage, evtType} === 5'h08) s1Stamp = evtStamp;
			if ({evtStage, evtType} === 5'h0A) chk("instant stamp", evtStamp, s1Stamp);
		end
	end
	initial begin
		#200_000;
		fails++;
		giveVerdict();
	end
	initial begin
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		ang <= $random(seed);
		grp <= $random(seed);
		bus(sa(0, STG_CFG), 0, 0, q); chk("cfg reset", q, CFG_RESET);
		bus(sa(0, STG_PICKUP), 0, 0, q); chk("pickup reset", q, 32'(PICKUP_RESET));
		bus(sa(0, STG_RELDLY), 0, 0, q); chk("release reset", q, 32'(RELDLY_RESET));
		bus(8'hFC, 0, 0, q); chk("unmapped", q, 32'h0000_0000);
		bus(sa(0, STG_DELAY), 1, 32'h0000_0003, q);
		bus(sa(1, STG_CFG), 1, 32'h0000_3D00, q);
		bus(sa(2, STG_PICKUP), 1, 32'h0000_FFFF, q);
		bus(REG_IRQ_MASK, 1, 32'h0000_0008, q);
		$display("test registers done");
		// Stage 1 has start OFF disabled, so that event must never appear.
		expq = '{5'h00, 5'h08, 5'h0A, 5'h1C, 5'h02, 5'h01, 5'h03, 5'h0B, 5'h1D};
		blockIn <= 4'b1000;
		neg <= 16'h0100 + 16'($random(seed) & 8'hFF);
		n = 0;
		while (startOut[0] !== 1'b1 && n < 100) begin
			@(posedge ref_clk);
			n++;
		end
		#1;
		chk("instant trip", tripOut[1], 1'b1);
		chk("blocked", {blockedOut[3], startOut[3]}, 2'b10);
		chk("def early", tripOut[0], 1'b0);
		n = 0;
		while (tripOut[0] !== 1'b1 && n < 200) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		chk("def delay", n >= 2 * TK && n <= 3 * TK + 4, 1'b1);
		$display("test operate done");
		@(posedge ref_clk);
		neg <= 16'h0000;
		repeat (80) @(posedge ref_clk);
		chk("pending", expq.size(), 0);
		chk("irq set", irq, 1'b1);
		bus(REG_IRQ_STATUS, 0, 0, q); chk("status", q, 32'h0000_181B);
		#1;
		chk("irq clear", irq, 1'b0);
		bus(REG_IRQ_STATUS, 0, 0, q); chk("status cleared", q, 32'h0000_0000);
		bus(REG_REC_SEL, 0, 0, q); chk("record count", q, 32'h0000_0050);
		// Newest record is the stage 0 trip ON; it tripped, so no time remains.
		bus(REG_REC_BASE + 8'h04, 0, 0, q); chk("record word1", q, {16'h0000, 5'h00, grp, 8'h02});
		bus(REG_REC_BASE + 8'h18, 0, 0, q); chk("record word6", q, {ang, 16'h0000});
		$display("test release done");
		rst <= 1'b1;
		@(posedge ref_clk);
		rst <= 1'b0;
		bus(REG_REC_SEL, 0, 0, q); chk("count after reset", q, 32'h0000_0000);
		bus(sa(1, STG_CFG), 0, 0, q); chk("cfg after reset", q, CFG_RESET);
		bus(REG_STAMP, 0, 0, q); chk("stamp after reset", q < 32'h0000_0002, 1'b1);
		$display("test reset done");
		giveVerdict();
	end
endmodule // tb_ubt_unbalance_timer
